// *** hdl/ubd_baud_regs.v ***
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "ubd_defs.vh"

// Behaviour
// - High divisor and control share one location
// - Select bit reads zero from high register
// - Bits 14:12 reserved, read zero
// - Divisor twelve bits: high four, low eight
// - Low write reloads prescaler immediately
// - Double speed drops factor sixteen to eight, outside sync mode
module ubd_baud_regs (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    resetn,
  // Avalon-MM slave
  input  wire [`UBD_ADDR_W-1:0]  address,
  input  wire                    read,
  input  wire                    write,
  input  wire [31:0]             writedata,
  input  wire [3:0]              byteenable,
  output reg  [31:0]             readdata,
  output reg                     waitrequest,
  // Baud outputs
  output reg                     baudTick,
  output reg                     bitTick,
  output reg  [`UBD_DIV_W-1:0]   baudDivisor,
  output reg  [`UBD_CTRL_W-1:0]  frameFormat,
  output reg                     doubleSpeedSelect
);

  // ---------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------
  // Bus handshake
  reg                    served;        // Answer given this cycle
  wire                   req;           // Request not yet answered

  // Write strobes
  wire                   wrLow;         // Low divisor write
  wire                   wrShared;      // Write to the shared word
  wire                   wrHigh;        // Shared write to the divisor
  wire                   wrCtrl;        // Shared write to control C
  wire                   wrSpeed;       // Speed register write

  // Prescaler link
  wire                   syncMode;      // Sync mode field of control C
  wire [`UBD_DIV_W-1:0]  loadDivisor;   // Value the prescaler loads
  wire                   baudTickRaw;   // Prescaler baud tick
  wire                   bitTickRaw;    // Prescaler bit tick

  // Read path
  reg  [31:0]            next_readdata; // Read mux result

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // Write hit on one register word with its byte lane enabled
  function hitLane;
    input [`UBD_ADDR_W-1:0] addr;
    input [`UBD_ADDR_W-1:0] idx;
    input [3:0]             be;
    input [1:0]             lane;
    begin
      hitLane = (addr == idx) && be[lane];
    end
  endfunction

  // ---------------------------------------------------------------
  // Request and write strobes
  // ---------------------------------------------------------------

  // Bus request present and not yet answered
  assign req = (read || write) && !served;

  // Write strobes are taken on the request edge
  assign wrLow    = req && write &&
    hitLane(address, `UBD_IDX_LOW, byteenable, `UBD_LANE_LO);
  assign wrShared = req && write &&
    hitLane(address, `UBD_IDX_HIGH_CTRL, byteenable, `UBD_LANE_HI);
  assign wrSpeed  = req && write &&
    hitLane(address, `UBD_IDX_SPEED, byteenable, `UBD_LANE_LO);

  // Select bit routes the shared word to one of two registers
  assign wrHigh = wrShared && !writedata[`UBD_SEL_BIT];
  assign wrCtrl = wrShared && writedata[`UBD_SEL_BIT];

  // Sync mode is a field of control C, not a separate copy
  assign syncMode = frameFormat[`UBD_FMT_SYNC];

  // ---------------------------------------------------------------
  // Handshake: one wait cycle, answer on the second
  // ---------------------------------------------------------------
  // served keeps a held request from being taken twice
  always @(posedge sys_clk) begin
    if (!resetn) begin
      served      <= 1'b0;
      waitrequest <= 1'b1;
    end else begin
      served      <= req;
      waitrequest <= !req;
    end
  end

  // ---------------------------------------------------------------
  // Divisor register, high and low halves
  // ---------------------------------------------------------------
  // Reserved shared-word bits 14:12 are never stored in the divisor
  always @(posedge sys_clk) begin
    if (!resetn) begin
      baudDivisor <= `UBD_RST_DIV;
    end else begin
      // Low half; the same strobe reloads the prescaler
      if (wrLow) begin
        baudDivisor[`UBD_LO_MSB:`UBD_LO_LSB] <=
          writedata[`UBD_LO_MSB:`UBD_LO_LSB];
      end
      // High half; no reload until the count runs out
      if (wrHigh) begin
        baudDivisor[`UBD_HI_MSB:`UBD_HI_LSB] <=
          writedata[`UBD_HI_MSB:`UBD_HI_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Frame-format control C and speed register
  // ---------------------------------------------------------------
  // Control C is written only with the select bit set
  always @(posedge sys_clk) begin
    if (!resetn) begin
      frameFormat <= `UBD_RST_CTRL;
    end else if (wrCtrl) begin
      frameFormat <= writedata[`UBD_CTRL_MSB:`UBD_CTRL_LSB];
    end
  end

  // Double speed; the prescaler ignores it in sync mode
  always @(posedge sys_clk) begin
    if (!resetn) begin
      doubleSpeedSelect <= `UBD_RST_DOUBLE;
    end else if (wrSpeed) begin
      doubleSpeedSelect <= writedata[`UBD_SPD_DOUBLE];
    end
  end

  // ---------------------------------------------------------------
  // Read mux; shared word shows divisor, select and reserved zero
  // ---------------------------------------------------------------
  always @* begin
    next_readdata = `UBD_RST_READ;
    case (address)
      `UBD_IDX_LOW: begin
        next_readdata[`UBD_LO_MSB:`UBD_LO_LSB] =
          baudDivisor[`UBD_LO_MSB:`UBD_LO_LSB];
      end
      // Control C is not readable here; reads see the divisor view
      `UBD_IDX_HIGH_CTRL: begin
        next_readdata[`UBD_HI_MSB:`UBD_HI_LSB] =
          baudDivisor[`UBD_HI_MSB:`UBD_HI_LSB];
      end
      `UBD_IDX_SPEED: begin
        next_readdata[`UBD_SPD_DOUBLE] = doubleSpeedSelect;
        next_readdata[`UBD_SPD_SYNC]   = syncMode;
      end
      // Whole divisor in one word
      `UBD_IDX_STATUS: begin
        next_readdata[`UBD_DIV_W-1:0] = baudDivisor;
      end
      default: begin
        next_readdata = `UBD_RST_READ;
      end
    endcase
  end

  // Read data loads on the request edge, held until the next read
  always @(posedge sys_clk) begin
    if (!resetn) begin
      readdata <= `UBD_RST_READ;
    end else if (req && read) begin
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler; divisor changes mid-frame are not guarded
  // ---------------------------------------------------------------
  // A low write forwards its byte so the reload sees the new value
  assign loadDivisor = wrLow ?
    {baudDivisor[`UBD_HI_MSB:`UBD_HI_LSB],
     writedata[`UBD_LO_MSB:`UBD_LO_LSB]} : baudDivisor;

  ubd_prescaler uPre (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .divisor     (loadDivisor),
    .reload      (wrLow),
    .doubleSpeed (doubleSpeedSelect),
    .syncMode    (syncMode),
    .baudTick    (baudTickRaw),
    .bitTick     (bitTickRaw)
  );

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  // Ticks leave through flops, one cycle behind the prescaler
  always @(posedge sys_clk) begin
    if (!resetn) begin
      baudTick <= 1'b0;
      bitTick  <= 1'b0;
    end else begin
      baudTick <= baudTickRaw;
      bitTick  <= bitTickRaw;
    end
  end

endmodule

// *** hdl/ubd_prescaler.v ***
`timescale 1ns/1ps
`include "ubd_defs.vh"

module ubd_prescaler (
  // Clock and reset
  input  wire                      sys_clk,
  input  wire                      resetn,
  // Divisor and reload
  input  wire [`UBD_DIV_W-1:0]     divisor,
  input  wire                      reload,
  input  wire                      doubleSpeed,
  input  wire                      syncMode,
  // Ticks
  output reg                       baudTick,
  output reg                       bitTick
);

  reg [`UBD_DIV_W-1:0]    count;
  reg [`UBD_FACTOR_W-1:0] phase;
  wire [`UBD_FACTOR_W-1:0] factor;

  // Double speed halves the factor only when asynchronous
  assign factor = (doubleSpeed && !syncMode) ?
                  `UBD_FACTOR_DOUBLE : `UBD_FACTOR_NORMAL;

  // ---------------------------------------------------------------
  // Down counter, tick at zero, reload on low write
  // ---------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (!resetn) begin
      count    <= `UBD_RST_DIV;
      phase    <= {`UBD_FACTOR_W{1'b0}};
      baudTick <= 1'b0;
      bitTick  <= 1'b0;
    end else if (reload) begin
      count    <= divisor;
      phase    <= {`UBD_FACTOR_W{1'b0}};
      baudTick <= 1'b0;
      bitTick  <= 1'b0;
    end else if (count == {`UBD_DIV_W{1'b0}}) begin
      count    <= divisor;
      baudTick <= 1'b1;
      // Wrap also when phase overshoots a lowered factor
      if (phase >= factor - 5'h01) begin
        phase   <= {`UBD_FACTOR_W{1'b0}};
        bitTick <= 1'b1;
      end else begin
        phase   <= phase + 5'h01;
        bitTick <= 1'b0;
      end
    end else begin
      count    <= count - 12'h001;
      baudTick <= 1'b0;
      bitTick  <= 1'b0;
    end
  end

endmodule

// *** shared/ubd_defs.vh ***
`ifndef UBD_DEFS_VH
`define UBD_DEFS_VH

// ---------------------------------------------------------------
// Register word indices on the Avalon-MM bus (byte address = 4*idx)
// ---------------------------------------------------------------
`define UBD_IDX_LOW        4'h0
`define UBD_IDX_HIGH_CTRL  4'h1
`define UBD_IDX_SPEED      4'h2
`define UBD_IDX_STATUS     4'h3
`define UBD_ADDR_W         4

// ---------------------------------------------------------------
// Field positions and widths
// ---------------------------------------------------------------
`define UBD_SEL_BIT        15
`define UBD_DIV_W          12
`define UBD_HI_MSB         11
`define UBD_HI_LSB         8
`define UBD_LO_MSB         7
`define UBD_LO_LSB         0
`define UBD_CTRL_W         7
`define UBD_CTRL_MSB       14
`define UBD_CTRL_LSB       8
`define UBD_FMT_SYNC       6
`define UBD_LANE_LO        2'h0
`define UBD_LANE_HI        2'h1
`define UBD_SPD_DOUBLE     0
`define UBD_SPD_SYNC       1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define UBD_RST_DIV        12'h000
`define UBD_RST_CTRL       7'h06
`define UBD_RST_SPEED      2'h0
`define UBD_RST_DOUBLE     1'h0
`define UBD_RST_READ       32'h00000000

// ---------------------------------------------------------------
// Oversampling factors
// ---------------------------------------------------------------
`define UBD_FACTOR_NORMAL  5'h10
`define UBD_FACTOR_DOUBLE  5'h08
`define UBD_FACTOR_W       5

`endif

// *** sim/ubd_baud_regs_asserts.sv ***
`timescale 1ns/1ps
// ------------------------
// Baud register checker
// ------------------------
module ubd_baud_regs_asserts (
  // Watched ports
  input logic        sys_clk,
  input logic        resetn,
  input logic [3:0]  address,
  input logic        read,
  input logic        write,
  input logic [31:0] writedata,
  input logic [3:0]  byteenable,
  input logic [31:0] readdata,
  input logic        waitrequest,
  input logic        baudTick,
  input logic        bitTick,
  input logic [11:0] baudDivisor,
  input logic [6:0]  frameFormat,
  input logic        doubleSpeedSelect
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic        rdHi;
  logic        hiWr;
  logic [1:0]  armCnt;
  logic        armB;
  logic [11:0] gap;
  logic [4:0]  nTick;
  // Answered accesses to the shared location
  assign rdHi = !waitrequest && read && address == 4'h1;
  assign hiWr = !waitrequest && write && address == 4'h1 && byteenable[1];
  // Cycles between ticks, baud ticks between bit ticks
  always @(posedge sys_clk) begin
    // Two ticks after any write, so the period uses the new divisor
    armCnt <= (!resetn || write) ? 2'h0 :
              (baudTick && armCnt != 2'h2) ? armCnt + 2'h1 : armCnt;
    armB  <= resetn && !write && (armB || bitTick);
    gap   <= baudTick ? 12'h000 : gap + 12'h001;
    nTick <= bitTick ? 5'h00 : nTick + {4'h0, baudTick};
  end
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bad answer");
  property p_sel;
    rdHi |-> !readdata[15];
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_rsvd;
    rdHi |-> readdata[14:12] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("bad reserved");
  property p_high;
    hiWr && !writedata[15] |-> baudDivisor[11:8] == writedata[11:8];
  endproperty
  a_high: assert property (p_high) else $error("bad high");
  property p_ctrl;
    hiWr && writedata[15] |-> frameFormat == writedata[14:8]
      && $stable(baudDivisor);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("bad control");
  property p_low;
    !waitrequest && write && address == 4'h0 && byteenable[0]
      |-> baudDivisor[7:0] == writedata[7:0];
  endproperty
  a_low: assert property (p_low) else $error("bad low");
  property p_period;
    baudTick && armCnt == 2'h2 |-> gap == baudDivisor;
  endproperty
  a_period: assert property (p_period) else $error("bad period");
  property p_bits;
    bitTick && armB |-> nTick + baudTick
      == (doubleSpeedSelect && !frameFormat[6] ? 5'h08 : 5'h10);
  endproperty
  a_bits: assert property (p_bits) else $error("bad factor");
endmodule

bind ubd_baud_regs ubd_baud_regs_asserts u_chk (
  .sys_clk, .resetn, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .baudTick, .bitTick, .baudDivisor,
  .frameFormat, .doubleSpeedSelect
);

// *** sim/ubd_baud_regs_tb_top.sv ***
`timescale 1ns/1ps
// ------------------------
// Baud register bench
// ------------------------
module ubd_baud_regs_tb_top;
  logic        sys_clk = 0;
  logic        resetn = 0;
  logic [3:0]  address = 0;
  logic        read = 0;
  logic        write = 0;
  logic [31:0] writedata = 0;
  logic [3:0]  byteenable = 0;
  logic [31:0] readdata, rd, d;
  logic        waitrequest, baudTick, bitTick, doubleSpeedSelect, w;
  logic [11:0] baudDivisor, expDiv;
  logic [6:0]  frameFormat, expFmt;
  logic [3:0]  a, be;
  logic        dbl;
  int          failures = 0, checks_done = 0, cyc = 0, n;
  ubd_baud_regs dut (.sys_clk, .resetn, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .baudTick,
    .bitTick, .baudDivisor, .frameFormat, .doubleSpeedSelect);
  // Clock
  initial forever #2 sys_clk = ~sys_clk;
  // Compare one value
  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] ad,
                     input logic [31:0] da, input logic [3:0] en);
    @(posedge sys_clk);
    address <= ad;
    writedata <= da;
    byteenable <= en;
    read <= !wr;
    write <= wr;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 0;
    write <= 0;
  endtask
  task automatic complete_run();
    if (failures == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(23));
    {expDiv, expFmt, dbl} = {12'h000, 7'h06, 1'b0};
    repeat (3) @(posedge sys_clk);
    resetn <= 1;
    repeat (200) begin
      a = $urandom_range(0, 5);
      {d, be, w} = {$urandom, 4'($urandom), 1'($urandom)};
      if (a == 1 && !d[15]) d[14:12] = 3'h0;
      bus(w, a, d, be);
      if (w && a == 0 && be[0]) expDiv[7:0] = d[7:0];
      if (w && a == 1 && be[1] && !d[15]) expDiv[11:8] = d[11:8];
      if (w && a == 1 && be[1] && d[15]) expFmt = d[14:8];
      if (w && a == 2 && be[0]) dbl = d[0];
      if (!w && a == 0) chk(rd, {24'h0, expDiv[7:0]}, "low");
      if (!w && a == 1) chk(rd, {20'h0, expDiv[11:8], 8'h0}, "high");
      if (!w && a == 2) chk(rd, {30'h0, expFmt[6], dbl}, "speed");
      if (!w && a == 3) chk(rd, {20'h0, expDiv}, "status");
      if (!w && a > 3) chk(rd, 0, "unmapped");
      chk(baudDivisor, expDiv, "divisor");
      chk(frameFormat, expFmt, "format");
      chk(doubleSpeedSelect, dbl, "double");
    end
    // Long divisor, then a short one must reload at once
    bus(1, 1, 0, 4'h2);
    bus(1, 0, 255, 4'h1);
    repeat (20) @(posedge sys_clk);
    bus(1, 0, 3, 4'h1);
    for (n = 0; baudTick !== 1'b1 && n < 9; n++) @(posedge sys_clk);
    chk(n < 9, 1, "reload");
    @(posedge sys_clk);
    for (n = 1; baudTick !== 1'b1 && n < 9; n++) @(posedge sys_clk);
    chk(n, 4, "period");
    // Oversampling factor per mode, divisor zero, no frame in flight
    bus(1, 0, 0, 4'h1);
    for (int k = 0; k < 3; k++) begin
      bus(1, 1, k == 2 ? 32'h0000C600 : 32'h00008600, 4'h2);
      chk(frameFormat, k == 2 ? 7'h46 : 7'h06, "mode");
      bus(1, 2, k == 0 ? 0 : 1, 4'h1);
      repeat (2) @(posedge sys_clk iff bitTick === 1'b1);
      @(posedge sys_clk);
      for (n = 1; bitTick !== 1'b1 && n < 40; n++) @(posedge sys_clk);
      chk(n, k == 1 ? 8 : 16, "factor");
    end
    complete_run();
  end
endmodule
